// *** debug_status_breakpoint_regs.sv ***
// Contract
// - registers reachable only by serial debug commands
// - control byte 8 bits, match 16 bits
// - permit ignores writes while background active
// - four status flags are read-only
// - clock select writable at any time except in wait/stop
// - bit 7 permits background, reset clears
// - bit 6 shows background active
// - breakpoint enable gates the comparator and the pending force; a tag reaching the queue end still enters background
// - force select: match forces background at boundary
// - tag select: tagged opcode enters background
// - bit 3 selects clock, defaults alternate
// - bit 2 shows wait/stop or woken state
// - low power blocks commands except background and status read
// - bit 1 flags access failed by wait/stop
// - no slow-access conflict ever reported
// - breakpoint enable resets to zero
// - match register only via breakpoint commands
// - serial data most significant bit first
`include "dbgsb_params.svh"

module debug_status_breakpoint_regs
   import dbgsb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic cmd_valid,
   input wire logic [`DBGSB_CMD_W-1:0] cmd_code,
   input wire logic [`DBGSB_BKPT_W-1:0] cmd_wdata,
   input wire logic cpu_wait_stop,
   input wire logic cpu_mem_fail,
   input wire logic cpu_instr_boundary,
   input wire logic cpu_go,
   input wire logic [`DBGSB_BKPT_W-1:0] cpu_address,
   input wire logic cpu_access,
   input wire logic cpu_opcode_fetch,
   input wire logic cpu_tag_at_queue_end,
   output logic [`DBGSB_BKPT_W-1:0] rdata,
   output logic rdata_valid,
   output logic cmd_accepted,
   output logic background_active_flag,
   output logic debug_clock_select,
   output logic enter_background,
   output logic tag_request
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic background_permit_reg;
   logic breakpoint_enable_reg;
   logic force_tag_select_reg;
   logic debug_clock_select_reg;
   logic wait_stop_failure_reg;
   logic woke_from_lowpwr_reg;
   logic force_pending_reg;
   logic [`DBGSB_BKPT_W-1:0] debug_breakpoint_address_reg;
   dbgsb_cpu_state_type cpu_state_reg;
   dbgsb_cpu_state_type cpu_state_next;
   logic force_hit;
   logic tag_hit;
   logic is_active;
   logic is_lowpwr;
   logic wr_ctrl;
   logic wr_bkpt;
   logic rd_status;
   logic rd_bkpt;
   logic bg_cmd;
   logic bg_enter;
   logic [`DBGSB_SCR_W-1:0] status_byte;

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   function automatic logic cmd_is(input logic [`DBGSB_CMD_W-1:0] code,
                                   input logic [`DBGSB_CMD_W-1:0] want);
      cmd_is = cmd_valid && (code == want);
   endfunction

   assign is_active = (cpu_state_reg == DBGSB_BACKGROUND);
   assign is_lowpwr = (cpu_state_reg == DBGSB_LOWPWR);
   // codes arrive whole, already shifted in msb first upstream
   // only the background and status read commands act while in wait or stop
   assign bg_cmd = cmd_is(cmd_code, `DBGSB_CMD_BACKGROUND);
   assign wr_ctrl = cmd_is(cmd_code, `DBGSB_CMD_WRITE_CONTROL) && !is_lowpwr;
   assign wr_bkpt = cmd_is(cmd_code, `DBGSB_CMD_BREAKPOINT_WRITE_COMMAND) && !is_lowpwr;
   assign rd_status = cmd_is(cmd_code, `DBGSB_CMD_READ_STATUS);
   assign rd_bkpt = cmd_is(cmd_code, `DBGSB_CMD_BREAKPOINT_READ_COMMAND) && !is_lowpwr;
   assign bg_enter = background_permit_reg && !is_active &&
                     (bg_cmd || (force_pending_reg && cpu_instr_boundary) ||
                      cpu_tag_at_queue_end);

   // ----------------------------------------
   // breakpoint comparator
   // ----------------------------------------
   dbgsb_bkpt_match u_match (
      .clk_sys(clk_sys),
      .reset(reset),
      .bkpt_enable(breakpoint_enable_reg),
      .force_tag_select(force_tag_select_reg),
      .match_address(debug_breakpoint_address_reg),
      .cpu_address(cpu_address),
      .cpu_access(cpu_access),
      .cpu_opcode_fetch(cpu_opcode_fetch),
      .force_request(force_hit),
      .tag_request(tag_hit)
   );

   // forced hit waits for the next instruction boundary
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         force_pending_reg <= 1'b0;
      end else if (bg_enter || !breakpoint_enable_reg) begin
         force_pending_reg <= 1'b0;
      end else if (force_hit) begin
         force_pending_reg <= 1'b1;
      end
   end

   // ----------------------------------------
   // control bits
   // ----------------------------------------
   // permit bit, frozen while background is active so it cannot be withdrawn
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         background_permit_reg <= 1'b0;
      end else if (wr_ctrl && !is_active) begin
         background_permit_reg <= cmd_wdata[`DBGSB_BIT_PERMIT];
      end
   end

   // breakpoint and clock controls, written whenever a control write is taken
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         breakpoint_enable_reg <= 1'b0;
         force_tag_select_reg <= 1'b0;
         debug_clock_select_reg <= 1'b0;
      end else if (wr_ctrl) begin
         breakpoint_enable_reg <= cmd_wdata[`DBGSB_BIT_BKPT_EN];
         force_tag_select_reg <= cmd_wdata[`DBGSB_BIT_FTS];
         debug_clock_select_reg <= cmd_wdata[`DBGSB_BIT_CLKSEL];
      end
   end

   // match register only written by its own command
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         debug_breakpoint_address_reg <= `DBGSB_BKPT_RESET;
      end else if (wr_bkpt) begin
         debug_breakpoint_address_reg <= cmd_wdata;
      end
   end

   // ----------------------------------------
   // processor run state
   // ----------------------------------------
   always_comb begin
      cpu_state_next = cpu_state_reg;
      case (cpu_state_reg)
         DBGSB_RUN: begin
            if (bg_enter) begin
               cpu_state_next = DBGSB_BACKGROUND;
            end else if (cpu_wait_stop) begin
               cpu_state_next = DBGSB_LOWPWR;
            end
         end
         DBGSB_LOWPWR: begin
            if (bg_enter) begin
               cpu_state_next = DBGSB_BACKGROUND;
            end else if (!cpu_wait_stop) begin
               cpu_state_next = DBGSB_RUN;
            end
         end
         DBGSB_BACKGROUND: begin
            if (cpu_go) begin
               cpu_state_next = DBGSB_RUN;
            end
         end
         default: begin
            cpu_state_next = DBGSB_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cpu_state_reg <= DBGSB_RUN;
      end else begin
         cpu_state_reg <= cpu_state_next;
      end
   end

   // remembers that background was reached from wait or stop
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         woke_from_lowpwr_reg <= 1'b0;
      end else if (is_lowpwr && bg_enter) begin
         woke_from_lowpwr_reg <= 1'b1;
      end else if (cpu_state_next == DBGSB_RUN) begin
         woke_from_lowpwr_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // failure flag, hardware set wins over clear
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wait_stop_failure_reg <= 1'b0;
      end else if (cpu_mem_fail) begin
         wait_stop_failure_reg <= 1'b1;
      end else if (bg_enter) begin
         wait_stop_failure_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // status byte assembly
   // ----------------------------------------
   always_comb begin
      status_byte = `DBGSB_SCR_CTRL_RESET;
      status_byte[`DBGSB_BIT_PERMIT] = background_permit_reg;
      status_byte[`DBGSB_BIT_ACTIVE] = is_active;
      status_byte[`DBGSB_BIT_BKPT_EN] = breakpoint_enable_reg;
      status_byte[`DBGSB_BIT_FTS] = force_tag_select_reg;
      status_byte[`DBGSB_BIT_CLKSEL] = debug_clock_select_reg;
      status_byte[`DBGSB_BIT_WS] = is_lowpwr || (is_active && woke_from_lowpwr_reg);
      status_byte[`DBGSB_BIT_WSF] = wait_stop_failure_reg;
      status_byte[`DBGSB_BIT_DVF] = 1'b0;
   end

   // ----------------------------------------
   // read answers and outputs
   // ----------------------------------------
   // one-cycle strobe that fresh read data stands on rdata
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rdata_valid <= 1'b0;
      end else begin
         rdata_valid <= rd_status || rd_bkpt;
      end
   end

   // read data holds until the next read command
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rdata <= `DBGSB_BKPT_RESET;
      end else if (rd_status) begin
         rdata <= {{(`DBGSB_BKPT_W-`DBGSB_SCR_W){1'b0}}, status_byte};
      end else if (rd_bkpt) begin
         rdata <= debug_breakpoint_address_reg;
      end
   end

   // acknowledge of every command not refused in wait/stop, background command acknowledged even when no entry follows
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cmd_accepted <= 1'b0;
      end else begin
         cmd_accepted <= wr_ctrl || wr_bkpt || rd_status || rd_bkpt || bg_cmd;
      end
   end

   // active flag follows the run state of this very edge
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         background_active_flag <= 1'b0;
      end else begin
         background_active_flag <= (cpu_state_next == DBGSB_BACKGROUND);
      end
   end

   // clock select copy for the serial clock mux
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         debug_clock_select <= 1'b0;
      end else begin
         debug_clock_select <= debug_clock_select_reg;
      end
   end

   // request to the core to stop and enter background
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         enter_background <= 1'b0;
      end else begin
         enter_background <= bg_enter;
      end
   end

   // tag for the fetched opcode, travels with it down the queue
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tag_request <= 1'b0;
      end else begin
         tag_request <= tag_hit;
      end
   end

endmodule

// *** dbgsb_params.svh ***
`ifndef DBGSB_PARAMS_SVH
`define DBGSB_PARAMS_SVH

// ----------------------------------------
// bit positions in the status/control byte
// ----------------------------------------
`define DBGSB_BIT_PERMIT 7
`define DBGSB_BIT_ACTIVE 6
`define DBGSB_BIT_BKPT_EN 5
`define DBGSB_BIT_FTS 4
`define DBGSB_BIT_CLKSEL 3
`define DBGSB_BIT_WS 2
`define DBGSB_BIT_WSF 1
`define DBGSB_BIT_DVF 0

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define DBGSB_SCR_W 8
`define DBGSB_BKPT_W 16
`define DBGSB_SCR_CTRL_RESET 8'h00
`define DBGSB_BKPT_RESET 16'h0000
`define DBGSB_CMD_W 8

// ----------------------------------------
// command codes seen by this block
// ----------------------------------------
`define DBGSB_CMD_READ_STATUS 8'hE4
`define DBGSB_CMD_WRITE_CONTROL 8'hC4
`define DBGSB_CMD_BREAKPOINT_READ_COMMAND 8'hE2
`define DBGSB_CMD_BREAKPOINT_WRITE_COMMAND 8'hC2
`define DBGSB_CMD_BACKGROUND 8'h90

`endif

// *** dbgsb_pkg.sv ***
package dbgsb_pkg;
   // ----------------------------------------
   // run state of the processor as seen by the debug logic
   // ----------------------------------------
   typedef enum logic [1:0] {
      DBGSB_RUN,
      DBGSB_LOWPWR,
      DBGSB_BACKGROUND
   } dbgsb_cpu_state_type;
endpackage

// *** dbgsb_bkpt_match.sv ***
`include "dbgsb_params.svh"

module dbgsb_bkpt_match
   import dbgsb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic bkpt_enable,
   input wire logic force_tag_select,
   input wire logic [`DBGSB_BKPT_W-1:0] match_address,
   input wire logic [`DBGSB_BKPT_W-1:0] cpu_address,
   input wire logic cpu_access,
   input wire logic cpu_opcode_fetch,
   output logic force_request,
   output logic tag_request
);

   // ----------------------------------------
   // address comparator
   // ----------------------------------------
   logic hit;
   assign hit = bkpt_enable && cpu_access && (cpu_address == match_address);

   // forced request on any matching access, tag only on opcode fetch
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         force_request <= 1'b0;
         tag_request <= 1'b0;
      end else begin
         force_request <= hit && force_tag_select;
         tag_request <= hit && !force_tag_select && cpu_opcode_fetch;
      end
   end

endmodule

// *** dbgsb_props.sv ***
`include "dbgsb_params.svh"

module dbgsb_props
   import dbgsb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic cmd_valid,
   input wire logic [`DBGSB_CMD_W-1:0] cmd_code,
   input wire logic [`DBGSB_BKPT_W-1:0] cmd_wdata,
   input wire logic cpu_wait_stop,
   input wire logic cpu_instr_boundary,
   input wire logic cpu_access,
   input wire logic cpu_opcode_fetch,
   input wire logic cpu_tag_at_queue_end,
   input wire logic [`DBGSB_BKPT_W-1:0] rdata,
   input wire logic rdata_valid,
   input wire logic cmd_accepted,
   input wire logic background_active_flag,
   input wire logic debug_clock_select,
   input wire logic enter_background,
   input wire logic tag_request
);
   // ----------------------------------------
   // command and fetch sequences
   // ----------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence s_cmd(logic [7:0] k);
      cmd_valid && cmd_code == k;
   endsequence
   // low power is only reachable after wait/stop was seen one cycle earlier
   sequence s_wr;
      s_cmd(`DBGSB_CMD_WRITE_CONTROL) ##0 !$past(cpu_wait_stop);
   endsequence
   // core held in wait/stop: not active now, not active before, wait/stop seen
   sequence s_wr_lowpwr;
      s_cmd(`DBGSB_CMD_WRITE_CONTROL) ##0 ($past(cpu_wait_stop) && !$past(reset)
         && !$past(background_active_flag) && !background_active_flag);
   endsequence
   sequence s_fetch;
      cpu_access && cpu_opcode_fetch;
   endsequence

   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_wr_taken; s_wr |=> cmd_accepted; endproperty
   a_wr_taken: assert property (p_wr_taken) else $error("control write lost");
   property p_wr_refused;
      s_wr_lowpwr |=> !cmd_accepted;
   endproperty
   a_wr_refused: assert property (p_wr_refused) else $error("write taken in low power");
   // control bit lands one edge after the write, the output flop one edge later
   property p_clk_sel;
      s_wr |-> ##2 debug_clock_select == $past(cmd_wdata[`DBGSB_BIT_CLKSEL], 2);
   endproperty
   a_clk_sel: assert property (p_clk_sel) else $error("clock select not written");
   property p_status;
      s_cmd(`DBGSB_CMD_READ_STATUS) |=> rdata_valid && rdata[15:8] == 8'h00 && rdata[0] == 1'h0;
   endproperty
   a_status: assert property (p_status) else $error("status read wrong");
   property p_bk_rd;
      s_cmd(`DBGSB_CMD_BREAKPOINT_READ_COMMAND) ##0 !$past(cpu_wait_stop) |=> rdata_valid;
   endproperty
   a_bk_rd: assert property (p_bk_rd) else $error("match read lost");
   property p_bg_taken; s_cmd(`DBGSB_CMD_BACKGROUND) |=> cmd_accepted; endproperty
   a_bg_taken: assert property (p_bg_taken) else $error("background refused");
   property p_entry_flag; enter_background |-> background_active_flag; endproperty
   a_entry_flag: assert property (p_entry_flag) else $error("active flag low on entry");
   property p_rise; $rose(background_active_flag) |-> enter_background; endproperty
   a_rise: assert property (p_rise) else $error("active flag rose alone");
   property p_cause;
      enter_background |-> $past(cmd_valid) || $past(cpu_instr_boundary)
         || $past(cpu_tag_at_queue_end);
   endproperty
   a_cause: assert property (p_cause) else $error("entry without cause");
   property p_tag;
      tag_request |-> $past(cpu_access, 2) && $past(cpu_opcode_fetch, 2);
   endproperty
   a_tag: assert property (p_tag) else $error("tag without fetch");
   c_tag: cover property (s_fetch ##2 tag_request);
endmodule

bind debug_status_breakpoint_regs dbgsb_props chk (
   .clk_sys(clk_sys),
   .reset(reset),
   .cmd_valid(cmd_valid),
   .cmd_code(cmd_code),
   .cmd_wdata(cmd_wdata),
   .cpu_wait_stop(cpu_wait_stop),
   .cpu_instr_boundary(cpu_instr_boundary),
   .cpu_access(cpu_access),
   .cpu_opcode_fetch(cpu_opcode_fetch),
   .cpu_tag_at_queue_end(cpu_tag_at_queue_end),
   .rdata(rdata),
   .rdata_valid(rdata_valid),
   .cmd_accepted(cmd_accepted),
   .background_active_flag(background_active_flag),
   .debug_clock_select(debug_clock_select),
   .enter_background(enter_background),
   .tag_request(tag_request)
);

// *** dbgsb_host.sv ***
module dbgsb_host (
   input wire logic clk_sys,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // host side: whole decoded commands, msb-first shifting done upstream
   // ----------------------------------------
   initial begin
      cmd_valid = 1'h0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   // one command per call, released lines show the inverse of the last value
   task automatic cmd(input logic [7:0] k, input logic [15:0] d);
      @(negedge clk_sys);
      cmd_valid = 1'h1;
      cmd_code = k;
      cmd_wdata = d;
      @(negedge clk_sys);
      cmd_valid = 1'h0;
      cmd_code = ~k;
      cmd_wdata = ~d;
   endtask
   // callers read status after every forced entry and recover after failure
endmodule

// *** debug_status_breakpoint_regs_tb.sv ***
`include "dbgsb_params.svh"

module debug_status_breakpoint_regs_tb;
   import dbgsb_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'h0, reset = 1'h1, ws = 1'h0, mf = 1'h0, ib = 1'h0, go = 1'h0;
   logic acc = 1'h0, of = 1'h0, tq = 1'h0, rv, ok, baf, dcs, eb, tr, cv;
   logic p = 0, a = 0, e = 0, f = 0, c = 0, w = 0, wf = 0;
   logic [7:0] cc, d;
   logic [15:0] ca = 16'h0000, cw, rd, bk;
   int bad_count = 0, n_tests = 0, ne, nt;
   dbgsb_host host (.clk_sys(clk_sys), .cmd_valid(cv), .cmd_code(cc), .cmd_wdata(cw));
   debug_status_breakpoint_regs uut (.clk_sys(clk_sys), .reset(reset), .cmd_valid(cv),
      .cmd_code(cc), .cmd_wdata(cw), .cpu_wait_stop(ws), .cpu_mem_fail(mf),
      .cpu_instr_boundary(ib), .cpu_go(go), .cpu_address(ca), .cpu_access(acc),
      .cpu_opcode_fetch(of), .cpu_tag_at_queue_end(tq), .rdata(rd), .rdata_valid(rv),
      .cmd_accepted(ok), .background_active_flag(baf), .debug_clock_select(dcs),
      .enter_background(eb), .tag_request(tr));
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // compare, model and stimulus helpers
   // ----------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      n_tests++;
      if (g !== x) begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic rs();
      host.cmd(`DBGSB_CMD_READ_STATUS, 16'h0000);
      chk({15'h0000, rv}, 16'h0001);
      chk(rd, {8'h00, p, a, e, f, c, w, wf, 1'h0});
   endtask
   task automatic wc(input logic [7:0] v);
      host.cmd(`DBGSB_CMD_WRITE_CONTROL, {8'h00, v});
      chk({15'h0000, ok}, {15'h0000, !w});
      if (!w) begin
         if (!a) p = v[7];
         {e, f, c} = v[5:3];
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk_sys) s = 1'h1;
      @(negedge clk_sys) s = 1'h0;
   endtask
   task automatic hit(input logic fe);
      @(negedge clk_sys) {acc, of, ca} = {2'h3 & {1'h1, fe}, bk};
      {ne, nt} = 0;
      repeat (5) begin
         @(negedge clk_sys) {acc, ib} = 2'h1;
         ne += eb;
         nt += tr;
      end
      ib = 1'h0;
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #100us;
      bad_count++;
      conclude();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      void'($urandom(39536));
      repeat (5) @(negedge clk_sys);
      reset = 1'h0;
      rs();
      host.cmd(`DBGSB_CMD_BREAKPOINT_READ_COMMAND, 16'h0000);
      chk(rd, 16'h0000);
      d = $urandom | 8'h87;
      wc(d);
      rs();
      chk({15'h0000, dcs}, {15'h0000, c});
      bk = $urandom;
      host.cmd(`DBGSB_CMD_BREAKPOINT_WRITE_COMMAND, bk);
      host.cmd(`DBGSB_CMD_BREAKPOINT_READ_COMMAND, 16'h0000);
      chk(rd, bk);
      $display("test registers done");
      host.cmd(`DBGSB_CMD_BACKGROUND, 16'h0000);
      chk({14'h0000, eb, baf}, 16'h0003);
      a = 1;
      rs();
      wc({4'h3, ~c, 3'h7});
      rs();
      pulse(go);
      a = 0;
      rs();
      $display("test background done");
      hit(1'h0);
      chk(ne[15:0], 16'h0001);
      a = 1;
      rs();
      pulse(go);
      a = 0;
      wc({4'h9, c, 3'h0});
      hit(1'h0);
      chk({ne[7:0], nt[7:0]}, 16'h0000);
      wc({4'hA, c, 3'h0});
      hit(1'h1);
      chk({ne[7:0], nt[7:0]}, 16'h0001);
      pulse(tq);
      chk({15'h0000, eb}, 16'h0001);
      a = 1;
      pulse(go);
      a = 0;
      $display("test breakpoint done");
      @(negedge clk_sys) ws = 1'h1;
      w = 1;
      wc(8'h80);
      rs();
      pulse(mf);
      wf = 1;
      rs();
      host.cmd(`DBGSB_CMD_BACKGROUND, 16'h0000);
      chk({15'h0000, eb}, 16'h0001);
      ws = 1'h0;
      {a, wf} = 2'h2;
      rs();
      w = 0;
      wc({4'h8, ~c, 3'h0});
      w = 1;
      pulse(go);
      {a, w} = 2'h0;
      rs();
      $display("test low power done");
      conclude();
   end
endmodule
